// ==== sebw_device.sv ====
// sebw_device: memory device end of the two-wire link, write path and polling
// assumes: bus lines resolved by surroundings; clk much faster than bus clock
`timescale 1ns/1ps
module sebw_device (
  input  wire logic                       clk,
  input  wire logic                       reset,
  sebw_if.device                          bus,
  input  wire logic                       chip_select_strap_0,
  input  wire logic                       chip_select_strap_1,
  input  wire logic                       chip_select_strap_2,
  input  wire logic                       write_protect,
  output logic                            standby,
  output logic                            programming,
  output logic                            wr_valid,
  output logic [sebw_pkg::ADDR_BITS-1:0]  wr_addr,
  output logic [7:0]                      wr_data
);
  typedef struct packed {
    logic [1:0]                    scl_s;
    logic [1:0]                    sda_s;
    logic [2:0]                    cs_s0;  // strap sync, first stage
    logic [2:0]                    cs_s1;  // strap sync, second stage
    logic                          scl_q;
    logic                          sda_q;
    sebw_pkg::sebw_dev_state_t     fsm;
    logic [3:0]                    bitc;
    logic [7:0]                    shreg;
    logic                          ack_pend;
    logic                          sda_low;
    logic [sebw_pkg::ADDR_BITS-1:0] addr;
    logic                          got_data;
    logic [1:0]                    wp_s;   // write-protect sync
    logic [22:0]                   prog_cnt;
    logic                          prog;
    logic                          idle;
  } sebw_dev_st_t;
  sebw_dev_st_t st;
  sebw_dev_st_t next_st;

  logic [7:0] pg_buf [128];           // page latch
  logic [127:0] pg_dirty;
  logic [7:0] array_mem [sebw_pkg::MEM_BYTES]; // 512 pages x 128 bytes
  logic [sebw_pkg::ADDR_BITS-1:0] pg_base;
  logic [7:0] prog_idx;
  logic scl_r;
  logic scl_f;
  logic start_ev;
  logic stop_ev;
  logic buf_we;
  logic fifo_in_ready;
  logic fifo_valid;
  logic [sebw_pkg::ADDR_BITS+7:0] fifo_data;
  logic [2:0] straps;

  assign straps = st.cs_s1;

  // edge and condition detection on synchronised lines
  assign scl_r    = st.scl_s[1] & ~st.scl_q;
  assign scl_f    = ~st.scl_s[1] & st.scl_q;
  assign start_ev = st.scl_s[1] & st.scl_q & st.sda_q & ~st.sda_s[1];
  assign stop_ev  = st.scl_s[1] & st.scl_q & ~st.sda_q & st.sda_s[1];
  assign pg_base  = {st.addr[sebw_pkg::ADDR_BITS-1:sebw_pkg::PAGE_BITS], 7'h00};
  assign buf_we   = scl_f && st.fsm == sebw_pkg::SEBW_S_DATA && st.bitc == sebw_pkg::BIT_ACK
                    && st.ack_pend;

  // next-state logic
  always_comb begin
    next_st = st;
    next_st.scl_s = {st.scl_s[0], bus.scl};
    next_st.sda_s = {st.sda_s[0], bus.sda};
    next_st.scl_q = st.scl_s[1];
    next_st.sda_q = st.sda_s[1];
    next_st.cs_s0 = {chip_select_strap_2, chip_select_strap_1, chip_select_strap_0};
    next_st.cs_s1 = st.cs_s0;
    next_st.wp_s = {st.wp_s[0], write_protect};
    if (st.prog) begin
      // self-timed cycle, bus ignored
      next_st.fsm = sebw_pkg::SEBW_S_IDLE;
      next_st.sda_low = 1'b0;
      if (st.prog_cnt == 23'(sebw_pkg::PROG_CYCLES - 1)) begin
        next_st.prog = 1'b0;
        next_st.idle = 1'b1;
      end else begin
        next_st.prog_cnt = st.prog_cnt + 23'h000001;
      end
    end else if (stop_ev) begin
      next_st.sda_low = 1'b0;
      next_st.fsm = sebw_pkg::SEBW_S_IDLE;
      if (st.got_data && !st.wp_s[1]) begin
        next_st.prog = 1'b1;
        next_st.prog_cnt = '0;
        next_st.idle = 1'b0;
      end else begin
        next_st.idle = 1'b1;
      end
      next_st.got_data = 1'b0;
    end else if (start_ev) begin
      next_st.fsm = sebw_pkg::SEBW_S_DEV;
      next_st.bitc = '0;
      next_st.sda_low = 1'b0;
      next_st.idle = 1'b0;
      next_st.got_data = 1'b0;
    end else if (st.fsm != sebw_pkg::SEBW_S_IDLE) begin
      if (scl_r && st.bitc <= sebw_pkg::BIT_LAST) begin
        next_st.shreg = {st.shreg[6:0], st.sda_s[1]};
        next_st.bitc = st.bitc + 4'h1;
      end
      if (scl_f && st.bitc == sebw_pkg::BIT_ACK) begin
        if (!st.ack_pend) begin
          // ninth clock starts: decide acknowledge
          next_st.ack_pend = 1'b1;
          case (st.fsm)
            sebw_pkg::SEBW_S_DEV: begin
              if (st.shreg[7:4] == sebw_pkg::DEV_PREFIX && st.shreg[3:1] == straps) begin
                next_st.sda_low = 1'b1;
              end else begin
                next_st.fsm = sebw_pkg::SEBW_S_IDLE;
                next_st.idle = 1'b1;
                next_st.ack_pend = 1'b0;
              end
            end
            sebw_pkg::SEBW_S_AHI: begin
              next_st.addr[15:8] = st.shreg;
              next_st.sda_low = 1'b1;
            end
            sebw_pkg::SEBW_S_ALO: begin
              next_st.addr[7:0] = st.shreg;
              next_st.sda_low = 1'b1;
            end
            sebw_pkg::SEBW_S_DATA: begin
              next_st.sda_low = 1'b1;
              next_st.got_data = 1'b1;
            end
            default: next_st.sda_low = 1'b0;
          endcase
        end else begin
          // ninth clock ends: release and advance
          next_st.ack_pend = 1'b0;
          next_st.sda_low = 1'b0;
          next_st.bitc = '0;
          case (st.fsm)
            sebw_pkg::SEBW_S_DEV:
              next_st.fsm = st.shreg[0] ? sebw_pkg::SEBW_S_READ : sebw_pkg::SEBW_S_AHI;
            sebw_pkg::SEBW_S_AHI: next_st.fsm = sebw_pkg::SEBW_S_ALO;
            sebw_pkg::SEBW_S_ALO: next_st.fsm = sebw_pkg::SEBW_S_DATA;
            sebw_pkg::SEBW_S_DATA:
              next_st.addr = {st.addr[15:7], st.addr[6:0] + 7'h01};
            default: next_st.fsm = sebw_pkg::SEBW_S_SKIP;       // read path not served
          endcase
        end
      end
    end
  end

  // registered state, power-up into standby
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
      st.scl_s <= 2'h3;
      st.sda_s <= 2'h3;
      st.scl_q <= 1'b1;
      st.sda_q <= 1'b1;
      st.idle <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // page latch: clear on any start condition, fill per data byte
  always_ff @(posedge clk) begin
    if (reset || start_ev) begin
      pg_dirty <= '0;
    end else if (buf_we) begin
      pg_buf[st.addr[6:0]] <= st.shreg;
      pg_dirty[st.addr[6:0]] <= 1'b1;
    end else if (prog_idx[7] == 1'b0 && st.prog && fifo_in_ready) begin
      pg_dirty[prog_idx[6:0]] <= 1'b0;
    end
  end

  // walk the page latch during programming, one byte per cycle into the queue
  always_ff @(posedge clk) begin
    if (reset || !st.prog) begin
      prog_idx <= '0;
    end else if (prog_idx[7] == 1'b0 && (fifo_in_ready || !pg_dirty[prog_idx[6:0]])) begin
      prog_idx <= prog_idx + 8'h01;
    end
  end

  sebw_fifo #(.WIDTH(sebw_pkg::ADDR_BITS + 8), .DEPTH(sebw_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (st.prog && !prog_idx[7] && pg_dirty[prog_idx[6:0]]),
    .in_ready  (fifo_in_ready),
    .in_data   ({pg_base | {9'h000, prog_idx[6:0]}, pg_buf[prog_idx[6:0]]}),
    .out_valid (fifo_valid),
    .out_ready (1'b1),
    .out_data  (fifo_data)
  );

  // array commit and write report
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_valid <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
    end else begin
      wr_valid <= fifo_valid;
      wr_addr <= fifo_data[23:8];
      wr_data <= fifo_data[7:0];
    end
    if (fifo_valid) array_mem[fifo_data[23:8]] <= fifo_data[7:0];
  end

  assign bus.sda_d_oe_n = ~st.sda_low;
  assign standby = st.idle;
  assign programming = st.prog;
endmodule

// ==== sebw_pkg.sv ====
// sebw_pkg: constants and types shared by both ends of the two-wire memory link
// assumes: 50 MHz system clock on both ends
package sebw_pkg;
  localparam int unsigned CLK_HZ            = 50_000_000;
  // internal_program_time, in microseconds, and its cycle count (longest time: round down)
  localparam int unsigned PROG_TIME_US      = 5000;
  localparam int unsigned PROG_CYCLES       = (CLK_HZ / 1_000_000) * PROG_TIME_US;
  localparam logic [3:0]  DEV_PREFIX        = 4'ha;
  localparam int unsigned PAGE_BITS         = 7;
  localparam int unsigned ADDR_BITS         = 16;
  localparam int unsigned MEM_BYTES         = 65536;
  localparam logic [3:0]  BIT_LAST          = 4'h7;
  localparam logic [3:0]  BIT_ACK           = 4'h8;
  // host bus clock divider: a quarter bit is HALF_DIV+1 system cycles (link period 400 ns)
  localparam logic [7:0]  HALF_DIV          = 8'h04;
  localparam int unsigned FIFO_DEPTH        = 4;

  typedef enum logic [2:0] {
    SEBW_S_IDLE = 3'b000,
    SEBW_S_DEV  = 3'b001,
    SEBW_S_AHI  = 3'b010,
    SEBW_S_ALO  = 3'b011,
    SEBW_S_DATA = 3'b100,
    SEBW_S_READ = 3'b101,
    SEBW_S_SKIP = 3'b110
  } sebw_dev_state_t;

  typedef enum logic [3:0] {
    SEBW_H_IDLE  = 4'b0000,
    SEBW_H_START = 4'b0001,
    SEBW_H_BIT   = 4'b0010,
    SEBW_H_ACK   = 4'b0011,
    SEBW_H_STOP  = 4'b0100,
    SEBW_H_STOP2 = 4'b0101,
    SEBW_H_REC   = 4'b0110,
    SEBW_H_DONE  = 4'b0111
  } sebw_host_state_t;

  // host commands on its user port
  localparam logic [1:0] CMD_BYTE  = 2'h0; // send byte, report ack
  localparam logic [1:0] CMD_START = 2'h1; // start then byte
  localparam logic [1:0] CMD_STOP  = 2'h2; // stop condition
  localparam logic [1:0] CMD_RECOV = 2'h3; // bus recovery sequence
endpackage

// ==== sebw_if.sv ====
// sebw_if: the two-wire link between bus controller and memory device
// assumes: testbench resolves the open-drain wires from the output enables
`timescale 1ns/1ps
interface sebw_if;
  logic scl_o;     // controller drives clock low
  logic scl_oe_n;  // low while controller pulls clock low
  logic sda_m_oe_n; // low while controller pulls data low
  logic sda_d_oe_n; // low while device pulls data low
  logic scl;       // resolved clock level
  logic sda;       // resolved data level
  modport host (output scl_o, output scl_oe_n, output sda_m_oe_n, input scl, input sda);
  modport device (output sda_d_oe_n, input scl, input sda);
endinterface

// ==== sebw_fifo.sv ====
// sebw_fifo: small valid/ready buffer, width and depth as parameters
// assumes: single clock, synchronous active-high reset
`timescale 1ns/1ps
module sebw_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } sebw_fifo_st_t;
  sebw_fifo_st_t st;
  sebw_fifo_st_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // handshake flags
  assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[st.rp];

  // pointer and count update
  always_comb begin
    next_st = st;
    if (push) next_st.wp = st.wp + 1'b1;
    if (pop) next_st.rp = st.rp + 1'b1;
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // storage and state
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
    if (push) mem[st.wp] <= in_data;
  end
endmodule

// ==== sebw_host.sv ====
// sebw_host: bus controller end, issues start, bytes, stop and recovery
// assumes: one command at a time; bus clock made here by a divider
`timescale 1ns/1ps
module sebw_host (
  input  wire logic       clk,
  input  wire logic       reset,
  sebw_if.host            bus,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic [1:0] cmd,
  input  wire logic [7:0] cmd_data,
  output logic            done,
  output logic            acked
);
  typedef struct packed {
    sebw_pkg::sebw_host_state_t fsm;
    logic [7:0] div;
    logic [1:0] ph;      // quarter phase in a bit
    logic [3:0] bitc;
    logic [7:0] shreg;
    logic       scl_low;
    logic       sda_low;
    logic       ack;
    logic       done;
    logic [1:0] sda_s;
  } sebw_host_st_t;
  sebw_host_st_t st;
  sebw_host_st_t next_st;
  logic tick;

  assign tick = (st.div == sebw_pkg::HALF_DIV);

  // sequencer: each tick advances a quarter of a bus bit
  always_comb begin
    next_st = st;
    next_st.sda_s = {st.sda_s[0], bus.sda};
    next_st.done = 1'b0;
    next_st.div = tick ? 8'h00 : st.div + 8'h01;
    case (st.fsm)
      sebw_pkg::SEBW_H_IDLE: begin
        next_st.ph = '0;
        if (cmd_valid) begin
          next_st.shreg = cmd_data;
          next_st.bitc = '0;
          case (cmd)
            sebw_pkg::CMD_START: next_st.fsm = sebw_pkg::SEBW_H_START;
            sebw_pkg::CMD_STOP:  next_st.fsm = sebw_pkg::SEBW_H_STOP;
            sebw_pkg::CMD_RECOV: next_st.fsm = sebw_pkg::SEBW_H_REC;
            default:             next_st.fsm = sebw_pkg::SEBW_H_BIT;
          endcase
        end
      end
      sebw_pkg::SEBW_H_START: if (tick) begin
        // data high, clock high, then data falls
        next_st.ph = st.ph + 2'h1;
        case (st.ph)
          2'h0: begin next_st.sda_low = 1'b0; end
          2'h1: next_st.scl_low = 1'b0;
          2'h2: next_st.sda_low = 1'b1;
          default: begin next_st.scl_low = 1'b1; next_st.fsm = sebw_pkg::SEBW_H_BIT; end
        endcase
      end
      sebw_pkg::SEBW_H_BIT, sebw_pkg::SEBW_H_ACK, sebw_pkg::SEBW_H_REC: if (tick) begin
        // data set while clock low, clock pulse, sample
        next_st.ph = st.ph + 2'h1;
        case (st.ph)
          2'h0: begin
            next_st.scl_low = 1'b1;
            next_st.sda_low = (st.fsm == sebw_pkg::SEBW_H_BIT) ? ~st.shreg[7] : 1'b0;
          end
          2'h1: next_st.scl_low = 1'b0;
          2'h2: if (st.fsm == sebw_pkg::SEBW_H_ACK) next_st.ack = ~st.sda_s[1];
          default: begin
            next_st.scl_low = 1'b1;
            next_st.shreg = {st.shreg[6:0], 1'b0};
            next_st.bitc = st.bitc + 4'h1;
            if (st.fsm == sebw_pkg::SEBW_H_BIT && st.bitc == sebw_pkg::BIT_LAST) begin
              next_st.fsm = sebw_pkg::SEBW_H_ACK;
            end else if (st.fsm == sebw_pkg::SEBW_H_REC && st.bitc == sebw_pkg::BIT_ACK) begin
              next_st.fsm = sebw_pkg::SEBW_H_STOP2;
            end else if (st.fsm == sebw_pkg::SEBW_H_ACK) begin
              next_st.fsm = sebw_pkg::SEBW_H_DONE;
            end
          end
        endcase
      end
      sebw_pkg::SEBW_H_STOP2, sebw_pkg::SEBW_H_STOP: if (tick) begin
        // optional start, then data low to high under high clock
        next_st.ph = st.ph + 2'h1;
        case (st.ph)
          2'h0: next_st.sda_low = (st.fsm == sebw_pkg::SEBW_H_STOP2) ? 1'b0 : 1'b1;
          2'h1: next_st.scl_low = 1'b0;
          2'h2: next_st.sda_low = 1'b1;
          default: begin
            if (st.fsm == sebw_pkg::SEBW_H_STOP2) begin
              next_st.fsm = sebw_pkg::SEBW_H_STOP;
            end else begin
              next_st.sda_low = 1'b0;
              next_st.fsm = sebw_pkg::SEBW_H_DONE;
            end
          end
        endcase
      end
      sebw_pkg::SEBW_H_DONE: begin
        next_st.done = 1'b1;
        next_st.fsm = sebw_pkg::SEBW_H_IDLE;
      end
      default: next_st.fsm = sebw_pkg::SEBW_H_IDLE;
    endcase
  end

  // state register, bus released after reset
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
      st.sda_s <= 2'h3;
    end else begin
      st <= next_st;
    end
  end

  assign cmd_ready = (st.fsm == sebw_pkg::SEBW_H_IDLE);
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe_n = ~st.scl_low;
  assign bus.sda_m_oe_n = ~st.sda_low;
  assign done = st.done;
  assign acked = st.ack;
endmodule

// ==== sebw_properties.sv ====
// sebw_properties: timing checks on the two-wire link between the two ends
// assumes: instantiated beside the interface, sharing clk and reset of the ends
`timescale 1ns/1ps
module sebw_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic sda_m_oe_n,
  input wire logic sda_d_oe_n,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_n;
  logic [1:0] ack_rises;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // clock rises since start, and rises seen while the device holds data low
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      bit_n     <= 4'h0;
      ack_rises <= 2'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
        bit_n <= 4'h0;
      end else if (scl && !scl_q) begin
        bit_n <= (bit_n == 4'h9) ? 4'h1 : bit_n + 4'h1;
      end
      if (sda_d_oe_n) begin
        ack_rises <= 2'h0;
      end else if (scl && !scl_q && ack_rises != 2'h3) begin
        ack_rises <= ack_rises + 2'h1;
      end
    end
  end

  a_dev_chg_low: assert property ($changed(sda_d_oe_n) |-> !scl)
    else $error("device changed data while clock high");
  a_ack_in_slot: assert property (!sda_d_oe_n && scl && scl_q |-> bit_n == 4'h9)
    else $error("device drove data outside the ninth clock");
  a_host_frees_ack: assert property (scl && scl_q && bit_n == 4'h9 |-> sda_m_oe_n)
    else $error("controller held data during the ninth clock");
  a_ack_once: assert property (ack_rises <= 2'h1)
    else $error("device drive spanned more than one clock");
  a_ack_full_bit: assert property ($rose(sda_d_oe_n) |-> ack_rises == 2'h1)
    else $error("device released data before its clock pulse");
  a_start_hold: assert property ($fell(sda_m_oe_n) && scl && scl_q |-> scl [*2])
    else $error("clock fell right after start");
  a_stop_hold: assert property ($rose(sda_m_oe_n) && scl && scl_q |-> scl [*2])
    else $error("clock fell right after stop");
  a_clock_high_min: assert property ($rose(scl) |-> scl [*3])
    else $error("clock high phase too short");
  a_clock_low_min: assert property ($fell(scl) |-> !scl [*3])
    else $error("clock low phase too short");
endmodule

// ==== testbench.sv ====
// testbench: controller and memory ends joined by the link
// assumes: design package compiled first; open-drain wires resolved here
`timescale 1ns/1ps
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
  logic        clk        = 1'b0;
  logic        reset      = 1'b1;
  logic        cmd_valid  = 1'b0;
  logic [1:0]  cmd        = 2'h0;
  logic [7:0]  cmd_data   = 8'h00;
  logic        cmd_ready;
  logic        done;
  logic        acked;
  logic [2:0]  strap      = 3'b101;
  logic        wp         = 1'b0;
  logic        standby;
  logic        programming;
  logic        wr_valid;
  logic [15:0] wr_addr;
  logic [7:0]  wr_data;
  logic        ack_seen;
  logic [15:0] wa [$];
  logic [7:0]  wd [$];
  int          fail_count = 0;
  int          compares   = 0;
  int          cycles     = 0;
  int          k;
  logic [7:0]  bad [3]    = '{8'h5a, 8'ha2, 8'hac};
  logic [7:0]  pg [5]     = '{8'haa, 8'h12, 8'h7e, 8'hc1, 8'hc2};
  // commits leave in page-slot order, so the wrapped byte comes first
  logic [15:0] ea [3]     = '{16'h1200, 16'h127e, 16'h127f};
  logic [7:0]  ed [3]     = '{8'hc3, 8'hc1, 8'hc2};

  sebw_if link ();
  // open-drain wires: low when any end pulls low
  assign link.scl = link.scl_oe_n ? 1'b1 : link.scl_o;
  assign link.sda = link.sda_m_oe_n & link.sda_d_oe_n;

  always #10 clk = ~clk;

  sebw_host u_sebw_host (.clk(clk), .reset(reset), .bus(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .cmd_data(cmd_data), .done(done), .acked(acked));
  sebw_device u_sebw_device (.clk(clk), .reset(reset), .bus(link),
    .chip_select_strap_0(strap[0]), .chip_select_strap_1(strap[1]),
    .chip_select_strap_2(strap[2]), .write_protect(wp), .standby(standby),
    .programming(programming), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data));
  sebw_properties u_sebw_properties (.clk(clk), .reset(reset), .scl_o(link.scl_o),
    .scl_oe_n(link.scl_oe_n), .sda_m_oe_n(link.sda_m_oe_n), .sda_d_oe_n(link.sda_d_oe_n),
    .scl(link.scl), .sda(link.sda));

  // record every byte committed to the array
  always @(posedge clk) begin
    if (wr_valid === 1'b1) begin
      wa.push_back(wr_addr);
      wd.push_back(wr_data);
    end
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done();
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one command: held until taken, then wait for done; ends at a falling edge
  task automatic send(input logic [1:0] c, input logic [7:0] d, output logic a);
    logic r;
    int   n;
    r = 1'b0;
    n = 0;
    @(posedge clk);
    cmd       <= c;
    cmd_data  <= d;
    cmd_valid <= 1'b1;
    while (!r) begin
      @(negedge clk);
      r = (cmd_ready === 1'b1);
      @(posedge clk);
    end
    cmd_valid <= 1'b0;
    r = 1'b0;
    while (!r && n < 5000) begin
      @(negedge clk);
      r = (done === 1'b1);
      n++;
    end
    `CHECK(r, 1'b1)
    a = acked;
  endtask

  task automatic xfer(input logic [1:0] c, input logic [7:0] d, input logic exp_ack);
    logic a;
    send(c, d, a);
    `CHECK(a, exp_ack)
  endtask

  task automatic stop_bus();
    logic a;
    send(sebw_pkg::CMD_STOP, 8'h00, a);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    `CHECK(standby, 1'b1)
    `CHECK(programming, 1'b0)
    foreach (bad[i]) begin
      xfer(sebw_pkg::CMD_START, bad[i], 1'b0);
      stop_bus();
      `CHECK(standby, 1'b1)
    end
    xfer(sebw_pkg::CMD_START, 8'hab, 1'b1);
    stop_bus();
    idle(20);
    `CHECK(standby, 1'b1)
    xfer(sebw_pkg::CMD_START, 8'haa, 1'b1);
    xfer(sebw_pkg::CMD_BYTE, 8'h00, 1'b1);
    send(sebw_pkg::CMD_RECOV, 8'h00, ack_seen);
    idle(4);
    `CHECK(standby, 1'b1)
    xfer(sebw_pkg::CMD_START, 8'haa, 1'b1);
    stop_bus();
    idle(50);
    `CHECK(programming, 1'b0)
    @(posedge clk);
    wp <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      xfer(i == 0 ? sebw_pkg::CMD_START : sebw_pkg::CMD_BYTE, pg[i], 1'b1);
    end
    stop_bus();
    idle(50);
    `CHECK(programming, 1'b0)
    `CHECK(wa.size(), 0)
    @(posedge clk);
    wp <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      xfer(i == 0 ? sebw_pkg::CMD_START : sebw_pkg::CMD_BYTE, pg[i], 1'b1);
    end
    xfer(sebw_pkg::CMD_BYTE, 8'hc3, 1'b1);
    `CHECK(wa.size(), 0)
    stop_bus();
    idle(20);
    `CHECK(programming, 1'b1)
    `CHECK(standby, 1'b0)
    k = 0;
    while (wa.size() < 3 && k < 2000) begin
      idle(1);
      k++;
    end
    `CHECK(wa.size(), 3)
    for (int i = 0; i < 3 && i < wa.size(); i++) begin
      `CHECK(wa[i], ea[i])
      `CHECK(wd[i], ed[i])
    end
    xfer(sebw_pkg::CMD_START, 8'haa, 1'b0);
    stop_bus();
    `CHECK(programming, 1'b1)
    @(posedge clk);
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    `CHECK(programming, 1'b0)
    `CHECK(standby, 1'b1)
    // new strap setting, then a byte write through the commit queue
    @(posedge clk);
    strap <= 3'b010;
    xfer(sebw_pkg::CMD_START, 8'haa, 1'b0);
    stop_bus();
    xfer(sebw_pkg::CMD_START, 8'ha4, 1'b1);
    xfer(sebw_pkg::CMD_BYTE, 8'h01, 1'b1);
    xfer(sebw_pkg::CMD_BYTE, 8'h02, 1'b1);
    xfer(sebw_pkg::CMD_BYTE, 8'h5c, 1'b1);
    stop_bus();
    idle(100);
    `CHECK(programming, 1'b1)
    `CHECK(wa.size(), 4)
    `CHECK(wa[3], 16'h0102)
    `CHECK(wd[3], 8'h5c)
    test_done();
  end
endmodule
